// ===== src/interleave_correction_control.sv
/*
 Control, status and freeze decision of the interleave correction engine.
 Assumes a decoded byte register port and 8-bit samples on clk_sys.
*/
`timescale 1ns/1ps
module interleave_correction_control #(
	parameter int SETTLE_CYCLES = icc_pkg::SETTLE_CYC
) (
	input  wire logic        clk_sys,       // Sample clock
	input  wire logic        rst,           // Async reset
	input  wire logic [12:0] reg_addr,      // Register address
	input  wire logic [7:0]  reg_wdata,     // Write data
	input  wire logic        reg_wr,        // Write strobe
	input  wire logic        reg_rd,        // Read strobe
	output logic      [7:0]  reg_rdata,     // Read data
	input  wire logic [7:0]  sample_in,     // Sample, two's complement
	output logic      [7:0]  offset_adj,    // Offset trim
	output logic      [7:0]  gain_adj,      // Gain trim
	output logic      [7:0]  skew_adj,      // Skew trim
	output logic             engine_active, // Engine running
	output logic             notch_active   // Notch in path
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] index_q, ctrl_q, static_q, pdown_q, hyst_q, ac_hyst_q;
	logic [7:0] static_lat_q, rdata_q, status;
	logic [15:0] thr_q, ac_thr_q;
	logic run_now, run_prev_q, start, frozen, upd, notch_on, per_end;

	function automatic logic hit(logic [12:0] a, logic [12:0] addr, logic wr);
		return wr && (addr == a);
	endfunction

	// Host writes; status is not writable
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			index_q   <= icc_pkg::REG_RST;
			ctrl_q    <= icc_pkg::REG_RST;
			static_q  <= icc_pkg::REG_RST;
			pdown_q   <= icc_pkg::REG_RST;
			hyst_q    <= icc_pkg::REG_RST;
			ac_hyst_q <= icc_pkg::REG_RST;
			thr_q     <= icc_pkg::THR_RST;
			ac_thr_q  <= icc_pkg::AC_THR_RST;
		end
		else
		begin
			if (hit(icc_pkg::ADDR_INDEX, reg_addr, reg_wr))
				index_q <= reg_wdata;
			if (hit(icc_pkg::ADDR_CTRL, reg_addr, reg_wr))
				ctrl_q <= reg_wdata;
			if (hit(icc_pkg::ADDR_STATIC, reg_addr, reg_wr))
				static_q <= reg_wdata;
			if (hit(icc_pkg::ADDR_PDOWN, reg_addr, reg_wr))
				pdown_q <= reg_wdata;
			if (hit(icc_pkg::ADDR_THR_LO, reg_addr, reg_wr))
				thr_q[7:0] <= reg_wdata;
			if (hit(icc_pkg::ADDR_THR_HI, reg_addr, reg_wr))
				thr_q[15:8] <= reg_wdata;
			if (hit(icc_pkg::ADDR_HYST, reg_addr, reg_wr))
				hyst_q <= reg_wdata;
			if (hit(icc_pkg::ADDR_AC_HYST, reg_addr, reg_wr))
				ac_hyst_q <= reg_wdata;
			// Extended AC threshold only behind the index value
			if (index_q == icc_pkg::INDEX_AC)
			begin
				if (hit(icc_pkg::ADDR_AC_THR_HI, reg_addr, reg_wr))
					ac_thr_q[15:8] <= reg_wdata;
				if (hit(icc_pkg::ADDR_AC_THR_LO, reg_addr, reg_wr))
					ac_thr_q[7:0] <= reg_wdata;
			end
		end

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	assign run_now  = ctrl_q[icc_pkg::CTRL_RUN] && !pdown_q[icc_pkg::PD_ENGINE];
	assign start    = run_now && !run_prev_q;
	assign frozen   = ctrl_q[icc_pkg::CTRL_FREEZE];
	assign upd      = run_now && !frozen;
	assign notch_on = ctrl_q[icc_pkg::CTRL_NOTCH] && !pdown_q[icc_pkg::PD_NOTCH];

	// Turn-on edge and static settings capture
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			run_prev_q   <= 1'b0;
			static_lat_q <= icc_pkg::REG_RST;
		end
		else
		begin
			run_prev_q <= run_now;
			if (start)
				static_lat_q <= static_q;
		end

	// ----------------------------------------
	// Sample path
	// ----------------------------------------
	logic signed [11:0] x, x1_q, x2_q, y, hp, est;
	logic signed [12:0] nsum, diff;
	assign x    = $signed({sample_in, 4'h0});
	assign nsum = {x[11], x} + {x2_q[11], x2_q};
	assign diff = {x[11], x} - {x1_q[11], x1_q};
	assign y    = nsum[12:1];
	assign hp   = diff[12:1];
	assign est  = notch_on ? y : x;

	// Two-tap history, notch at a quarter of the rate
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			x1_q <= '0;
			x2_q <= '0;
		end
		else
		begin
			x1_q <= x;
			x2_q <= x1_q;
		end

	function automatic logic [23:0] sq(logic signed [11:0] v);
		logic signed [23:0] p;
		p = v * v;
		return p;
	endfunction

	function automatic logic [15:0] mag(logic signed [11:0] v);
		return 16'(v[11] ? -13'(v) : 13'(v));
	endfunction

	// ----------------------------------------
	// Power meters
	// ----------------------------------------
	logic [3:0]  cnt_q;
	logic [26:0] acc_p_q, acc_ac_q;
	logic [23:0] avg_p, avg_ac;
	logic        sum_en;
	assign per_end = run_now && (cnt_q == 4'(icc_pkg::METER_CYC - 1));
	assign sum_en  = cnt_q < 4'(icc_pkg::AVG_N);
	assign avg_p   = 24'(acc_p_q >> icc_pkg::AVG_SH);
	assign avg_ac  = 24'(acc_ac_q >> icc_pkg::AVG_SH);

	// Squares summed over part of each period
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			cnt_q    <= '0;
			acc_p_q  <= '0;
			acc_ac_q <= '0;
		end
		else if (!run_now || per_end)
		begin
			cnt_q    <= '0;
			acc_p_q  <= '0;
			acc_ac_q <= '0;
		end
		else
		begin
			cnt_q <= cnt_q + 4'h1;
			if (sum_en)
			begin
				acc_p_q  <= acc_p_q + 27'(sq(x));
				acc_ac_q <= acc_ac_q + 27'(sq(hp));
			end
		end

	function automatic icc_pkg::hold_e hold_next(icc_pkg::hold_e st, logic [23:0] avg,
		logic [15:0] thr, logic [7:0] hy);
		logic [24:0] t, th;
		t  = {5'h00, thr, 4'h0};
		th = t + {13'h0000, hy, 4'h0};
		case (st)
			icc_pkg::ST_TRACK: hold_next = ({1'b0, avg} < t) ? icc_pkg::ST_HOLD : st;
			icc_pkg::ST_HOLD:  hold_next = ({1'b0, avg} >= th) ? icc_pkg::ST_TRACK : st;
			default:           hold_next = icc_pkg::ST_TRACK;
		endcase
	endfunction

	// Track/Hold decisions once per period
	icc_pkg::hold_e rms_st_q, ac_st_q;
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			rms_st_q <= icc_pkg::ST_TRACK;
			ac_st_q  <= icc_pkg::ST_TRACK;
		end
		else if (start)
		begin
			rms_st_q <= icc_pkg::ST_TRACK;
			ac_st_q  <= icc_pkg::ST_TRACK;
		end
		else if (per_end)
		begin
			rms_st_q <= hold_next(rms_st_q, avg_p, thr_q, hyst_q);
			ac_st_q  <= hold_next(ac_st_q, avg_ac, ac_thr_q, ac_hyst_q);
		end

	// ----------------------------------------
	// Engine sequence and settling
	// ----------------------------------------
	icc_pkg::eng_e eng_q;
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
			eng_q <= icc_pkg::ENG_OFF;
		else
			case (eng_q)
				icc_pkg::ENG_OFF:
					if (start)
						eng_q <= static_q[icc_pkg::STATIC_SKIP] ? icc_pkg::ENG_FINE
							: icc_pkg::ENG_COARSE;
				icc_pkg::ENG_COARSE:
					if (!run_now)
						eng_q <= icc_pkg::ENG_OFF;
					else if (per_end && upd)
						eng_q <= icc_pkg::ENG_FINE;
				icc_pkg::ENG_FINE:
					if (!run_now)
						eng_q <= icc_pkg::ENG_OFF;
				default:
					eng_q <= icc_pkg::ENG_OFF;
			endcase

	logic [29:0] settle_q;
	logic        settled_q;
	// Settling time restarts at each turn-on
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			settle_q  <= '0;
			settled_q <= 1'b0;
		end
		else if (start)
		begin
			settle_q  <= '0;
			settled_q <= 1'b0;
		end
		else if (upd && !settled_q)
		begin
			if (settle_q == 30'(SETTLE_CYCLES - 1))
				settled_q <= 1'b1;
			else
				settle_q <= settle_q + 30'h1;
		end

	// ----------------------------------------
	// Mismatch estimates and trims
	// ----------------------------------------
	logic               phase_q, gn_ok, sk_ok;
	logic signed [15:0] ofs_e_q, gn_e_q, sk_e_q;
	assign gn_ok = rms_st_q == icc_pkg::ST_TRACK;
	assign sk_ok = gn_ok && (ac_st_q == icc_pkg::ST_TRACK);

	// Odd samples come from the non-reference core
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			phase_q <= 1'b0;
			ofs_e_q <= '0;
			gn_e_q  <= '0;
			sk_e_q  <= '0;
		end
		else if (!run_now || per_end)
		begin
			phase_q <= 1'b0;
			ofs_e_q <= '0;
			gn_e_q  <= '0;
			sk_e_q  <= '0;
		end
		else
		begin
			phase_q <= !phase_q;
			if (upd && sum_en)
			begin
				ofs_e_q <= phase_q ? ofs_e_q - 16'(est) : ofs_e_q + 16'(est);
				if (gn_ok)
					gn_e_q <= phase_q ? gn_e_q - mag(est) : gn_e_q + mag(est);
				if (sk_ok)
					sk_e_q <= phase_q ? sk_e_q - mag(hp) : sk_e_q + mag(hp);
			end
		end

	function automatic logic [7:0] trim(logic [7:0] adj, logic signed [15:0] err,
		logic [7:0] step);
		trim = adj;
		if (err > 0)
			trim = (adj > 8'hff - step) ? 8'hff : adj + step;
		else if (err < 0)
			trim = (adj < step) ? 8'h00 : adj - step;
	endfunction

	logic [7:0] ofs_q, gn_q, sk_q, step;
	assign step = (eng_q == icc_pkg::ENG_COARSE) ? icc_pkg::STEP_CRS : icc_pkg::STEP_FINE;

	// Trims move once per period while allowed
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			ofs_q <= icc_pkg::ADJ_MID;
			gn_q  <= icc_pkg::ADJ_MID;
			sk_q  <= icc_pkg::ADJ_MID;
		end
		else if (start)
		begin
			ofs_q <= icc_pkg::ADJ_MID;
			gn_q  <= icc_pkg::ADJ_MID;
			sk_q  <= icc_pkg::ADJ_MID;
		end
		else if (per_end && upd && eng_q != icc_pkg::ENG_OFF)
		begin
			if (!ctrl_q[icc_pkg::CTRL_NO_OFS])
				ofs_q <= trim(ofs_q, ofs_e_q, step);
			if (!ctrl_q[icc_pkg::CTRL_NO_GN] && gn_ok)
				gn_q <= trim(gn_q, gn_e_q, step);
			if (!ctrl_q[icc_pkg::CTRL_NO_SK] && sk_ok)
				sk_q <= trim(sk_q, sk_e_q, step);
		end

	// ----------------------------------------
	// Read path and outputs
	// ----------------------------------------
	always_comb
	begin
		status = 8'h00;
		status[icc_pkg::ST_LOWP]    = rms_st_q == icc_pkg::ST_HOLD;
		status[icc_pkg::ST_LOWAC]   = ac_st_q == icc_pkg::ST_HOLD;
		status[icc_pkg::ST_SETTLED] = settled_q;
	end

	// Registered read, unmapped reads zero
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
			rdata_q <= 8'h00;
		else if (reg_rd)
			case (reg_addr)
				icc_pkg::ADDR_INDEX:   rdata_q <= index_q;
				icc_pkg::ADDR_STATUS:  rdata_q <= status;
				icc_pkg::ADDR_CTRL:    rdata_q <= ctrl_q;
				icc_pkg::ADDR_STATIC:  rdata_q <= static_q;
				icc_pkg::ADDR_PDOWN:   rdata_q <= pdown_q;
				icc_pkg::ADDR_THR_LO:  rdata_q <= thr_q[7:0];
				icc_pkg::ADDR_THR_HI:  rdata_q <= thr_q[15:8];
				icc_pkg::ADDR_HYST:    rdata_q <= hyst_q;
				icc_pkg::ADDR_AC_HYST: rdata_q <= ac_hyst_q;
				default:               rdata_q <= 8'h00;
			endcase

	assign reg_rdata     = rdata_q;
	assign offset_adj    = ofs_q;
	assign gain_adj      = gn_q;
	assign skew_adj      = sk_q;
	assign engine_active = eng_q != icc_pkg::ENG_OFF;
	assign notch_active  = notch_on;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_calm;
		!start;
	endsequence
	sequence s_rms_fall;
		per_end && rms_st_q == icc_pkg::ST_TRACK && {1'b0, avg_p} < {5'h00, thr_q, 4'h0};
	endsequence

	low_power_freeze_a: assert property ((status[0] and s_calm) |=>
		$stable(gain_adj) && $stable(skew_adj)) else $error("trim moved in power hold");
	low_ac_freeze_a: assert property ((status[1] and s_calm) |=> $stable(skew_adj))
		else $error("skew moved in AC hold");
	settle_clear_a: assert property (start |=> !status[2] [*2])
		else $error("settled flag after start");
	ctrl_write_a: assert property (hit(icc_pkg::ADDR_CTRL, reg_addr, reg_wr)
		|=> ctrl_q == $past(reg_wdata)) else $error("control write lost");
	engine_off_a: assert property (!run_now |=> !engine_active)
		else $error("engine active while off");
	freeze_hold_a: assert property ((frozen and s_calm) |=> $stable(offset_adj)
		&& $stable(gain_adj) && $stable(skew_adj)) else $error("trim moved frozen");
	offset_disable_a: assert property ((ctrl_q[2] and s_calm) |=> $stable(offset_adj))
		else $error("disabled offset moved");
	notch_path_a: assert property (notch_on |-> est == y)
		else $error("notch not in path");
	static_sample_a: assert property (!start |=> $stable(static_lat_q))
		else $error("static settings changed while running");
	power_down_a: assert property (pdown_q[0] |-> ##1 !engine_active)
		else $error("engine runs while powered down");
	rms_enter_a: assert property ((s_rms_fall and s_calm) |=> status[0])
		else $error("no hold below threshold");
endmodule

// ===== src/icc_pkg.sv
/*
 Constants for the interleave correction control block.
 Assumes a byte-wide register port and one sample clock.
*/
package icc_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [12:0] ADDR_INDEX     = 13'h0010;
	localparam logic [12:0] ADDR_STATUS    = 13'h0030;
	localparam logic [12:0] ADDR_CTRL      = 13'h0031;
	localparam logic [12:0] ADDR_STATIC    = 13'h0032;
	localparam logic [12:0] ADDR_PDOWN     = 13'h004a;
	localparam logic [12:0] ADDR_THR_LO    = 13'h0050;
	localparam logic [12:0] ADDR_THR_HI    = 13'h0051;
	localparam logic [12:0] ADDR_HYST      = 13'h0052;
	localparam logic [12:0] ADDR_AC_HYST   = 13'h0055;
	localparam logic [12:0] ADDR_AC_THR_LO = 13'h014f;
	localparam logic [12:0] ADDR_AC_THR_HI = 13'h0150;
	localparam logic [7:0]  INDEX_AC       = 8'h80;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ST_LOWP     = 0;
	localparam int ST_LOWAC    = 1;
	localparam int ST_SETTLED  = 2;
	localparam int CTRL_RUN    = 0;
	localparam int CTRL_FREEZE = 1;
	localparam int CTRL_NO_OFS = 2;
	localparam int CTRL_NO_GN  = 3;
	localparam int CTRL_NO_SK  = 4;
	localparam int CTRL_NOTCH  = 5;
	localparam int STATIC_SKIP = 5;
	localparam int PD_ENGINE   = 0;
	localparam int PD_NOTCH    = 1;
	// ----------------------------------------
	// Reset values and steps
	// ----------------------------------------
	localparam logic [15:0] THR_RST    = 16'h1000;
	localparam logic [15:0] AC_THR_RST = 16'h1000;
	localparam logic [7:0]  REG_RST    = 8'h00;
	localparam logic [7:0]  ADJ_MID    = 8'h80;
	localparam logic [7:0]  STEP_CRS   = 8'h08;
	localparam logic [7:0]  STEP_FINE  = 8'h01;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS     = 100;
	localparam int METER_NS   = 1000;
	localparam int METER_CYC  = METER_NS / CLK_NS;
	localparam int AVG_N      = 8;
	localparam int AVG_SH     = $clog2(AVG_N);
	localparam int SETTLE_MS  = 1000;
	localparam int SETTLE_CYC = SETTLE_MS * 1000000 / CLK_NS;
	typedef enum logic {ST_TRACK, ST_HOLD} hold_e;
	typedef enum logic [1:0] {ENG_OFF, ENG_COARSE, ENG_FINE} eng_e;
endpackage

// ===== sim/host_port.sv
/*
 Host model driving the byte register port of the correction control block.
 Assumes strobes are sampled on the rising edge of clk_sys, one byte each.
*/
`timescale 1ns/1ps
module host_port (
	input  wire logic        clk_sys,   // Sample clock
	input  wire logic [7:0]  reg_rdata, // Read data
	output logic      [12:0] reg_addr,  // Register address
	output logic      [7:0]  reg_wdata, // Write data
	output logic             reg_wr,    // Write strobe
	output logic             reg_rd     // Read strobe
);
	// ----------------------------------------
	// Idle state of the port
	// ----------------------------------------
	initial
	begin
		reg_addr = 13'h1fff;
		reg_wdata = 8'hff;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One byte write; address and data scrambled once released
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk_sys);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// One byte read; data taken once the strobe edge has passed
	task automatic rd(input logic [12:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk_sys);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	endtask
	// Turn-on: static settings first, reserved bits kept clear
	task automatic start(input logic [7:0] s, input logic [7:0] c);
		wr(icc_pkg::ADDR_CTRL, 8'h00);
		wr(icc_pkg::ADDR_STATIC, s & 8'h61);
		wr(icc_pkg::ADDR_CTRL, c);
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	// Indexed AC threshold load, upper byte before lower
	task automatic ac_thr(input logic [15:0] t);
		wr(icc_pkg::ADDR_INDEX, icc_pkg::INDEX_AC);
		wr(icc_pkg::ADDR_AC_THR_HI, t[15:8]);
		wr(icc_pkg::ADDR_AC_THR_LO, t[7:0]);
	endtask
endmodule

// ===== sim/testbench.sv
/*
 Self-checking bench for the interleave correction control block.
 Assumes host_port as register master and icc_pkg constants.
*/
`timescale 1ns/1ps
module testbench;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic [12:0] reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic [7:0]  sample_in = 8'h00;
	logic [7:0]  offset_adj;
	logic [7:0]  gain_adj;
	logic [7:0]  skew_adj;
	logic        engine_active;
	logic        notch_active;
	logic [7:0]  s_even = 8'h00;
	logic [7:0]  s_odd = 8'h00;
	logic [1:0]  ph = 2'h0;
	logic        pair = 1'b0;
	logic [7:0]  v, g, k, o;
	int          mismatches = 0;
	int          n_checks = 0;
	int          cycles = 0;
	logic [12:0] ra [9] = '{icc_pkg::ADDR_STATUS, icc_pkg::ADDR_CTRL, icc_pkg::ADDR_STATIC,
		icc_pkg::ADDR_PDOWN, icc_pkg::ADDR_THR_LO, icc_pkg::ADDR_THR_HI, icc_pkg::ADDR_HYST,
		13'h0040, icc_pkg::ADDR_AC_THR_HI};
	logic [7:0]  rx [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
	// ----------------------------------------
	// Clock, samples and hang guard
	// ----------------------------------------
	always #50 clk_sys = ~clk_sys;
	// Alternate core samples, or pairs of each so the skew error gets a sign
	always @(posedge clk_sys)
	begin
		#1;
		sample_in = (pair ? ph[1] : ph[0]) ? s_odd : s_even;
		ph = ph + 2'h1;
	end
	// Cut a hung run short
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			give_verdict();
		end
	end
	host_port host (
		.clk_sys   (clk_sys),
		.reg_rdata (reg_rdata),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd)
	);
	interleave_correction_control #(.SETTLE_CYCLES(50)) dut (
		.clk_sys       (clk_sys),
		.rst           (rst),
		.reg_addr      (reg_addr),
		.reg_wdata     (reg_wdata),
		.reg_wr        (reg_wr),
		.reg_rd        (reg_rd),
		.reg_rdata     (reg_rdata),
		.sample_in     (sample_in),
		.offset_adj    (offset_adj),
		.gain_adj      (gain_adj),
		.skew_adj      (skew_adj),
		.engine_active (engine_active),
		.notch_active  (notch_active)
	);
	// ----------------------------------------
	// Check helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string w);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic st(input logic [7:0] m, input logic [7:0] e, input string w);
		logic [7:0] r;
		host.rd(icc_pkg::ADDR_STATUS, r);
		chk(r & m, e, w);
	endtask
	task automatic setin(input logic [7:0] e, input logic [7:0] od);
		s_even = e;
		s_odd = od;
		settle(40);
	endtask
	// Size of the first offset trim move after turn-on
	task automatic first_step(input logic [7:0] exp);
		int n;
		n = 0;
		while (offset_adj === 8'h80 && n < 60)
		begin
			settle(1);
			n++;
		end
		chk((offset_adj > 8'h80) ? offset_adj - 8'h80 : 8'h80 - offset_adj, exp, "first step");
	endtask
	task automatic give_verdict();
		if (mismatches == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		settle(8);
		rst = 1'b0;
		for (int i = 0; i < 9; i++)
		begin
			host.rd(ra[i], v);
			chk(v, rx[i], "reset value");
		end
		host.wr(icc_pkg::ADDR_STATUS, 8'hff);
		st(8'hff, 8'h00, "status write");
		host.wr(icc_pkg::ADDR_CTRL, 8'h20);
		host.rd(icc_pkg::ADDR_CTRL, v);
		chk(v, 8'h20, "ctrl readback");
		chk({7'h00, notch_active}, 8'h01, "notch on");
		host.wr(icc_pkg::ADDR_PDOWN, 8'h02);
		chk({7'h00, notch_active}, 8'h00, "notch down");
		host.wr(icc_pkg::ADDR_PDOWN, 8'h00);
		// Settling with and without freeze
		s_even = 8'h60;
		s_odd = 8'ha0;
		host.start(8'h00, 8'h03);
		chk({7'h00, engine_active}, 8'h01, "engine on");
		settle(100);
		st(8'h04, 8'h00, "settle frozen");
		chk(offset_adj, 8'h80, "trim frozen");
		host.wr(icc_pkg::ADDR_CTRL, 8'h01);
		settle(100);
		st(8'h05, 8'h04, "settled");
		// Power threshold and hysteresis boundaries
		host.wr(icc_pkg::ADDR_HYST, 8'h10);
		setin(8'h10, 8'hf0);
		st(8'h01, 8'h00, "at threshold");
		setin(8'h00, 8'h00);
		st(8'h01, 8'h01, "low power");
		setin(8'h10, 8'hf0);
		st(8'h01, 8'h01, "inside hysteresis");
		setin(8'h11, 8'hef);
		st(8'h01, 8'h00, "above hysteresis");
		host.wr(icc_pkg::ADDR_THR_HI, 8'h20);
		settle(40);
		st(8'h01, 8'h01, "threshold placement");
		host.wr(icc_pkg::ADDR_THR_HI, 8'h10);
		// Power hold keeps offset running only
		s_even = 8'h08;
		s_odd = 8'h00;
		host.start(8'h00, 8'h01);
		settle(40);
		g = gain_adj;
		k = skew_adj;
		o = offset_adj;
		settle(40);
		st(8'h01, 8'h01, "rms hold");
		chk(gain_adj, g, "gain held");
		chk(skew_adj, k, "skew held");
		chk({7'h00, offset_adj !== o}, 8'h01, "offset runs");
		// AC hold and indexed threshold load
		pair = 1'b1;
		setin(8'h40, 8'h00);
		k = skew_adj;
		settle(40);
		chk({7'h00, skew_adj !== k}, 8'h01, "skew runs");
		// Small slope keeps a skew error while the AC meter reads low
		setin(8'h60, 8'h5f);
		st(8'h03, 8'h02, "low ac");
		k = skew_adj;
		settle(40);
		chk(skew_adj, k, "skew held ac");
		host.wr(icc_pkg::ADDR_AC_THR_HI, 8'h00);
		host.wr(icc_pkg::ADDR_AC_THR_LO, 8'h00);
		settle(40);
		st(8'h02, 8'h02, "unindexed write");
		host.ac_thr(16'h0000);
		settle(40);
		st(8'h02, 8'h00, "ac threshold");
		// Coarse skip chosen by static value at turn-on
		pair = 1'b0;
		s_even = 8'h60;
		s_odd = 8'h50;
		host.start(8'h20, 8'h01);
		first_step(8'h01);
		host.start(8'h00, 8'h01);
		first_step(8'h08);
		// Single-term disables
		for (int b = 2; b < 5; b++)
		begin
			pair = (b == 4);
			host.start(8'h00, 8'h01 | (8'h01 << b));
			settle(60);
			v = (b == 2) ? offset_adj : (b == 3) ? gain_adj : skew_adj;
			chk(v, 8'h80, "term disabled");
		end
		// Engine power-down
		host.wr(icc_pkg::ADDR_PDOWN, 8'h01);
		host.start(8'h00, 8'h01);
		o = offset_adj;
		settle(40);
		chk({7'h00, engine_active}, 8'h00, "engine down");
		chk(offset_adj, o, "trim idle");
		give_verdict();
	end
endmodule
